// *** pkg/dcfg_pkg.sv ***
// Constants for the converter device configuration register group.
// Function
// R1: Serial setup bit 7 set makes the serial data pin bidirectional.
// R2: Serial setup bit 6 selects LSB-first, clear selects MSB-first transfers.
// R3: Serial setup bit 5 holds the device in reset until written back low.
// R4: Power bit 7 powers down the in-phase channel; resets to zero.
// R5: Power bit 6 powers down the quadrature channel; resets to zero.
// R6: Power bit 5 powers down the data receiver; no samples accepted.
// R7: Power bit 4 powers down the temperature converter; resets to one.
// R8: Format bit 7 selects straight binary input, clear selects two's complement.
// R9: Format bit 6 selects quadrature sample first in each pair.
// R10: Format bit 5 reverses the input data port bit order.
// R11: Format bits 1:0 select word or byte width; codes 10, 11 invalid.
// R12: Enable bits 7 and 6 gate PLL lock lost and locked events.
// R13: Enable bits 5 and 4 gate sync lost and sync achieved events.
// R14: Enable bits 1 and 0 gate first and second FIFO warnings.
// R15: Each event flag stays latched until software writes one to it.
// R16: FIFO warnings rise when pointers differ by one and by two.
// R17: PLL lock lost latches when a previously locked PLL drops lock.
// R18: Interrupt output is high while any enabled event flag is set.
`default_nettype none
package dcfg_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [6:0] DCFG_OFS_SPSET = 7'h00;
	localparam logic [6:0] DCFG_OFS_PWR = 7'h01;
	localparam logic [6:0] DCFG_OFS_FMT = 7'h03;
	localparam logic [6:0] DCFG_OFS_IEN = 7'h04;
	localparam logic [6:0] DCFG_OFS_FLAG = 7'h06;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DCFG_B_SDIO_BIDIR = 7;
	localparam int DCFG_B_LSB_FIRST = 6;
	localparam int DCFG_B_SOFT_RST = 5;
	localparam int DCFG_B_PD_I = 7;
	localparam int DCFG_B_PD_Q = 6;
	localparam int DCFG_B_PD_RX = 5;
	localparam int DCFG_B_PD_AUX = 4;
	localparam int DCFG_B_BINARY = 7;
	localparam int DCFG_B_Q_FIRST = 6;
	localparam int DCFG_B_MSB_SWAP = 5;
	localparam int DCFG_B_LOCK_LOST = 7;
	localparam int DCFG_B_LOCKED = 6;
	localparam int DCFG_B_SYNC_LOST = 5;
	localparam int DCFG_B_SYNC_OK = 4;
	localparam int DCFG_B_FIFO_W1 = 1;
	localparam int DCFG_B_FIFO_W2 = 0;
	localparam int DCFG_BYTE_W = 7;
	// ----------------------------------------
	// Writable masks, reset values, width codes and transfer bit counts
	// ----------------------------------------
	localparam logic [7:0] DCFG_MSK_SPSET = 8'hE0;
	localparam logic [7:0] DCFG_MSK_PWR = 8'hF0;
	localparam logic [7:0] DCFG_MSK_FMT = 8'hE3;
	localparam logic [7:0] DCFG_MSK_IEN = 8'hF3;
	localparam logic [7:0] DCFG_RST_SPSET = 8'h00;
	localparam logic [7:0] DCFG_RST_PWR = 8'h10;
	localparam logic [7:0] DCFG_RST_FMT = 8'h00;
	localparam logic [7:0] DCFG_RST_IEN = 8'h00;
	localparam logic [1:0] DCFG_WID_WORD = 2'h0;
	localparam logic [1:0] DCFG_WID_BYTE = 2'h1;
	localparam logic [3:0] DCFG_CNT_LAST_INSTR = 4'h7;
	localparam logic [3:0] DCFG_CNT_LAST_DATA = 4'hF;
	localparam logic [3:0] DCFG_CNT_DATA0 = 4'h8;
endpackage
`default_nettype wire

// *** hw/dcfg_regs.sv ***
// Device configuration registers behind the 4-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module dcfg_regs import dcfg_pkg::*; #(
	parameter int DW = 14,
	parameter int PW = 3
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdio_in,
	output logic o_sdo,
	output logic o_sdio_out,
	output logic o_sdio_oe,
	input wire logic i_pll_locked,
	input wire logic i_sync_locked,
	input wire logic [PW-1:0] i_fifo_rd_ptr,
	input wire logic [PW-1:0] i_fifo_wr_ptr,
	input wire logic [DW-1:0] i_rx_data,
	input wire logic i_rx_valid,
	output logic [DW-1:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_soft_reset,
	output logic o_pwrdn_i,
	output logic o_pwrdn_q,
	output logic o_pwrdn_rx,
	output logic o_pwrdn_aux,
	output logic o_q_first,
	output logic [1:0] o_bus_width,
	output logic o_irq
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic sclk_m;
		logic sclk_q;
		logic sclk_d;
		logic cs_m;
		logic cs_q;
		logic sdi_m;
		logic sdi_q;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] instr;
		logic [7:0] rdat;
		logic sdo;
		logic sdo_oe;
		logic [7:0] spset;
		logic [7:0] pwr;
		logic [7:0] fmt;
		logic [7:0] ien;
		logic [7:0] flags;
		logic pll_q;
		logic sync_q;
		logic irq;
		logic [DW-1:0] rx_data;
		logic rx_valid;
	} dcfg_state_t;

	localparam dcfg_state_t ST_RST = '{
		sclk_m: 1'b0, sclk_q: 1'b0, sclk_d: 1'b0,
		cs_m: 1'b1, cs_q: 1'b1, sdi_m: 1'b0, sdi_q: 1'b0,
		cnt: 4'h0, sh: 8'h00, instr: 8'h00, rdat: 8'h00,
		sdo: 1'b0, sdo_oe: 1'b0,
		spset: DCFG_RST_SPSET, pwr: DCFG_RST_PWR, fmt: DCFG_RST_FMT,
		ien: DCFG_RST_IEN, flags: 8'h00,
		pll_q: 1'b0, sync_q: 1'b0, irq: 1'b0,
		rx_data: '0, rx_valid: 1'b0
	};

	dcfg_state_t st_r;
	dcfg_state_t st_nxt;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int k = 0; k < 8; k++) begin
			r[k] = v[7-k];
		end
		return r;
	endfunction

	// Byte mode uses only the low lanes, so the swap and the sign bit follow the width.
	function automatic logic [DW-1:0] rx_map(input logic [DW-1:0] v, input logic [7:0] f);
		logic [DW-1:0] r;
		r = v;
		if (f[DCFG_B_MSB_SWAP]) begin
			for (int k = 0; k < DW; k++) begin
				if (f[1:0] == DCFG_WID_BYTE) begin
					r[k] = (k < DCFG_BYTE_W) ? v[DCFG_BYTE_W-1-k] : 1'b0;
				end else begin
					r[k] = v[DW-1-k];
				end
			end
		end
		if (f[DCFG_B_BINARY]) begin
			if (f[1:0] == DCFG_WID_BYTE) begin
				r[DCFG_BYTE_W-1] = ~r[DCFG_BYTE_W-1];
			end else begin
				r[DW-1] = ~r[DW-1];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic sclk_rise;
	logic sclk_fall;
	logic [7:0] byte_in;
	logic [7:0] shifted;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [7:0] wdat;
	logic [6:0] wadr;
	logic wr_en;
	logic [PW-1:0] pdiff;
	logic [2:0] oidx;

	always_comb begin
		st_nxt = st_r;
		wr_en = 1'b0;
		wadr = st_r.instr[6:0];
		flag_clr = 8'h00;
		st_nxt.sclk_m = i_sclk;
		st_nxt.sclk_q = st_r.sclk_m;
		st_nxt.sclk_d = st_r.sclk_q;
		st_nxt.cs_m = i_cs_n;
		st_nxt.cs_q = st_r.cs_m;
		st_nxt.sdi_m = i_sdio_in;
		st_nxt.sdi_q = st_r.sdi_m;
		sclk_rise = st_r.sclk_q & ~st_r.sclk_d;
		sclk_fall = ~st_r.sclk_q & st_r.sclk_d;
		shifted = {st_r.sh[6:0], st_r.sdi_q};
		byte_in = st_r.spset[DCFG_B_LSB_FIRST] ? rev8(shifted) : shifted; // R2
		wdat = byte_in;
		oidx = 3'(st_r.cnt - DCFG_CNT_DATA0);
		if (st_r.cs_q) begin
			st_nxt.cnt = 4'h0;
			st_nxt.sdo_oe = 1'b0;
		end else begin
			if (sclk_rise) begin
				st_nxt.sh = shifted;
				st_nxt.cnt = 4'(st_r.cnt + 4'h1);
				if (st_r.cnt == DCFG_CNT_LAST_INSTR) begin
					st_nxt.instr = byte_in;
					unique case (byte_in[6:0])
						DCFG_OFS_SPSET: st_nxt.rdat = st_r.spset;
						DCFG_OFS_PWR: st_nxt.rdat = st_r.pwr;
						DCFG_OFS_FMT: st_nxt.rdat = st_r.fmt;
						DCFG_OFS_IEN: st_nxt.rdat = st_r.ien;
						DCFG_OFS_FLAG: st_nxt.rdat = st_r.flags;
						default: st_nxt.rdat = 8'h00;
					endcase
				end
				if (st_r.cnt == DCFG_CNT_LAST_DATA) begin
					wr_en = ~st_r.instr[7];
				end
			end
			if (sclk_fall && st_r.cnt[3] && st_r.instr[7]) begin
				st_nxt.sdo = st_r.spset[DCFG_B_LSB_FIRST] ? st_r.rdat[oidx] : st_r.rdat[3'h7 - oidx]; // R2
				st_nxt.sdo_oe = st_r.spset[DCFG_B_SDIO_BIDIR]; // R1
			end
		end
		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		if (wr_en) begin
			unique case (wadr)
				DCFG_OFS_SPSET: st_nxt.spset = wdat & DCFG_MSK_SPSET; // R1 R3
				DCFG_OFS_PWR: st_nxt.pwr = wdat & DCFG_MSK_PWR; // R4 R5 R6 R7
				DCFG_OFS_FMT: begin
					// An invalid width code is dropped and the old width kept.
					st_nxt.fmt = wdat & DCFG_MSK_FMT; // R8 R9 R10
					if (wdat[1]) begin
						st_nxt.fmt[1:0] = st_r.fmt[1:0]; // R11
					end
				end
				DCFG_OFS_IEN: st_nxt.ien = wdat & DCFG_MSK_IEN; // R12 R13 R14
				DCFG_OFS_FLAG: flag_clr = wdat & DCFG_MSK_IEN; // R15
				default: st_nxt.spset = st_nxt.spset;
			endcase
		end
		// ----------------------------------------
		// Event flags
		// ----------------------------------------
		st_nxt.pll_q = i_pll_locked;
		st_nxt.sync_q = i_sync_locked;
		pdiff = PW'(i_fifo_wr_ptr - i_fifo_rd_ptr);
		flag_set = 8'h00;
		flag_set[DCFG_B_LOCK_LOST] = st_r.pll_q & ~i_pll_locked; // R17
		flag_set[DCFG_B_LOCKED] = ~st_r.pll_q & i_pll_locked;
		flag_set[DCFG_B_SYNC_LOST] = st_r.sync_q & ~i_sync_locked;
		flag_set[DCFG_B_SYNC_OK] = ~st_r.sync_q & i_sync_locked;
		flag_set[DCFG_B_FIFO_W1] = (pdiff == PW'(1)); // R16
		flag_set[DCFG_B_FIFO_W2] = (pdiff == PW'(2)); // R16
		// A new event wins over a clear in the same cycle.
		st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set; // R15
		// ----------------------------------------
		// Soft reset holds the power, format, enable and flag registers at defaults
		// ----------------------------------------
		if (st_nxt.spset[DCFG_B_SOFT_RST]) begin
			st_nxt.pwr = DCFG_RST_PWR; // R3
			st_nxt.fmt = DCFG_RST_FMT;
			st_nxt.ien = DCFG_RST_IEN;
			st_nxt.flags = 8'h00;
		end
		st_nxt.irq = |(st_nxt.flags & st_nxt.ien); // R18
		// ----------------------------------------
		// Sample path
		// ----------------------------------------
		st_nxt.rx_valid = i_rx_valid & ~st_r.pwr[DCFG_B_PD_RX] & ~st_r.spset[DCFG_B_SOFT_RST]; // R6
		if (st_nxt.rx_valid) begin
			st_nxt.rx_data = rx_map(i_rx_data, st_r.fmt); // R8 R10
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= ST_RST;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_sdo = st_r.sdo;
	assign o_sdio_out = st_r.sdo;
	assign o_sdio_oe = st_r.sdo_oe;
	assign o_rx_data = st_r.rx_data;
	assign o_rx_valid = st_r.rx_valid;
	assign o_soft_reset = st_r.spset[DCFG_B_SOFT_RST];
	assign o_pwrdn_i = st_r.pwr[DCFG_B_PD_I]; // R4
	assign o_pwrdn_q = st_r.pwr[DCFG_B_PD_Q]; // R5
	assign o_pwrdn_rx = st_r.pwr[DCFG_B_PD_RX];
	assign o_pwrdn_aux = st_r.pwr[DCFG_B_PD_AUX]; // R7
	assign o_q_first = st_r.fmt[DCFG_B_Q_FIRST]; // R9
	assign o_bus_width = st_r.fmt[1:0];
	assign o_irq = st_r.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking dcfg_cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_lock_drop;
		i_ce && st_r.pll_q && !i_pll_locked;
	endsequence

	sequence s_flag_latched;
		st_r.flags[DCFG_B_LOCK_LOST] && !st_r.spset[DCFG_B_SOFT_RST];
	endsequence

	a_irq_level: assert property (i_ce |=> o_irq == |(st_r.flags & st_r.ien)) // R18
		else $error("Interrupt output does not match enabled flags.");
	a_lock_lost_set: assert property (s_lock_drop ##0 !o_soft_reset |=> s_flag_latched) // R17
		else $error("Lock lost flag not latched after lock drop.");
	a_fifo_warn_one: assert property (i_ce && !o_soft_reset
		&& PW'(i_fifo_wr_ptr - i_fifo_rd_ptr) == PW'(1) |=> st_r.flags[DCFG_B_FIFO_W1]) // R16
		else $error("First FIFO warning missed.");
	a_fifo_warn_two: assert property (i_ce && !o_soft_reset
		&& PW'(i_fifo_wr_ptr - i_fifo_rd_ptr) == PW'(2) |=> st_r.flags[DCFG_B_FIFO_W2]) // R16
		else $error("Second FIFO warning missed.");
	a_flag_stays: assert property (st_r.flags[DCFG_B_LOCK_LOST] && !o_soft_reset && !wr_en
		|=> st_r.flags[DCFG_B_LOCK_LOST]) // R15
		else $error("Event flag dropped without a clear.");
	a_rx_gated: assert property (i_ce && o_pwrdn_rx |=> !o_rx_valid) // R6
		else $error("Sample accepted while receiver powered down.");
	a_aux_reset: assert property ($past(i_rst) |-> o_pwrdn_aux && !o_pwrdn_i && !o_pwrdn_q) // R7
		else $error("Power control reset value wrong.");
	a_soft_hold: assert property (i_ce && o_soft_reset |=> st_r.ien == DCFG_RST_IEN
		&& st_r.pwr == DCFG_RST_PWR) // R3
		else $error("Soft reset does not hold registers at defaults.");
	a_width_valid: assert property (!o_bus_width[1]) // R11
		else $error("Invalid bus width stored.");
	a_sdio_dir: assert property (o_sdio_oe |-> st_r.spset[DCFG_B_SDIO_BIDIR]) // R1
		else $error("Data pin driven in receive-only mode.");
	a_swap_word: assert property (i_ce && i_rx_valid && !o_pwrdn_rx && !o_soft_reset
		&& st_r.fmt == 8'h20 |=> o_rx_data == {<<{$past(i_rx_data)}}) // R10
		else $error("Swapped sample order wrong.");
endmodule
`default_nettype wire

// *** tb/dcfg_host.sv ***
// Host model that drives the 4-wire serial port of the configuration registers.
`timescale 1ns/1ps
`default_nettype none
module dcfg_host (
	input wire logic i_clk,
	input wire logic i_sdo,
	input wire logic i_sdio_out,
	input wire logic i_sdio_oe,
	output logic o_sclk,
	output logic o_cs_n,
	output var logic o_sdio
);
	logic drv, hv, lsb, bidir;
	// A released line toggles each cycle, an even number of times between samples, so it reads back as the last bit driven.
	assign o_sdio = i_sdio_oe ? i_sdio_out : hv;
	initial begin
		o_sclk = 1'h0;
		o_cs_n = 1'h1;
		drv = 1'h1;
		hv = 1'h0;
		lsb = 1'h0;
		bidir = 1'h0;
	end
	always @(posedge i_clk) if (!drv) hv <= ~hv;
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [15:0] w;
		int k;
		w = {rd, a, wd};
		q = 8'h00;
		@(posedge i_clk);
		#1 o_cs_n = 1'h0;
		for (int i = 0; i < 16; i++) begin
			k = lsb ? ((i < 8) ? 8 + i : i - 8) : 15 - i;
			drv = !(rd && i > 7);
			if (drv) hv = w[k];
			repeat (8) @(posedge i_clk);
			#1;
			if (i > 7) q[k] = bidir ? o_sdio : i_sdo;
			o_sclk = 1'h1;
			repeat (8) @(posedge i_clk);
			#1 o_sclk = 1'h0;
		end
		repeat (8) @(posedge i_clk);
		#1 o_cs_n = 1'h1;
		drv = 1'h1;
		repeat (8) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the configuration registers.
`timescale 1ns/1ps
`default_nettype none
module tb_top import dcfg_pkg::*;;
	logic clk, rst, pll, syn, rxv, sclk, cs_n, sdio, sdo, so, oe, vld, srst, pi, pq, prx;
	logic paux, qf, irq, ce;
	logic [2:0] rp, wp;
	logic [13:0] rxd, rxo;
	logic [1:0] bw;
	logic [7:0] q;
	int failures, checks, cyc;
	dcfg_regs u_dcfg_regs (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_sdio_in(sdio), .o_sdo(sdo), .o_sdio_out(so), .o_sdio_oe(oe),
		.i_pll_locked(pll), .i_sync_locked(syn), .i_fifo_rd_ptr(rp), .i_fifo_wr_ptr(wp),
		.i_rx_data(rxd), .i_rx_valid(rxv), .o_rx_data(rxo), .o_rx_valid(vld),
		.o_soft_reset(srst), .o_pwrdn_i(pi), .o_pwrdn_q(pq), .o_pwrdn_rx(prx),
		.o_pwrdn_aux(paux), .o_q_first(qf), .o_bus_width(bw), .o_irq(irq));
	dcfg_host u_dcfg_host (.i_clk(clk), .i_sdo(sdo), .i_sdio_out(so), .i_sdio_oe(oe),
		.o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_dcfg_host.xfer(1'h0, a, d, q);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		u_dcfg_host.xfer(1'h1, a, 8'h00, q);
		chk($sformatf("reg %h", a), 16'(q), 16'(e));
	endtask
	task automatic stp(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic smp(input logic [13:0] d, input logic [13:0] e, input logic v);
		stp(1);
		rxd = d;
		rxv = 1'h1;
		stp(1);
		rxv = 1'h0;
		chk("valid", 16'(vld), 16'(v));
		if (v) chk("data", 16'(rxo), 16'(e));
	endtask
	function automatic logic [13:0] rev14(input logic [13:0] d);
		for (int i = 0; i < 14; i++) rev14[i] = d[13 - i];
	endfunction
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// The cycle ceiling is about four times the length of the sequence below.
	always @(negedge clk) begin
		cyc++;
		if (!u_dcfg_host.bidir) chk("oe", 16'(oe), 16'h0);
		if (cyc == 40000) begin
			failures++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{rst, ce, pll, syn, rxv, rp, wp, rxd} = {2'h3, 23'h0};
		stp(10);
		rst = 1'h0;
		chk("pwr", 16'({pi, pq, prx, paux}), 16'h1);
		rdc(DCFG_OFS_SPSET, 8'h00);
		rdc(DCFG_OFS_PWR, 8'h10);
		rdc(DCFG_OFS_FMT, 8'h00);
		rdc(DCFG_OFS_IEN, 8'h00);
		rdc(7'h02, 8'h00);
		smp(14'h1005, 14'h1005, 1'h1);
		wr(DCFG_OFS_FMT, 8'h80);
		smp(14'h1005, 14'h3005, 1'h1);
		wr(DCFG_OFS_FMT, 8'hA0);
		smp(14'h1005, rev14(14'h1005) ^ 14'h2000, 1'h1);
		wr(DCFG_OFS_FMT, 8'h20);
		smp(14'h1005, rev14(14'h1005), 1'h1);
		wr(DCFG_OFS_FMT, 8'hA1);
		smp(14'h3FC5, 14'h0011, 1'h1);
		wr(DCFG_OFS_FMT, 8'h41);
		chk("fmt", 16'({qf, bw}), 16'({1'h1, DCFG_WID_BYTE}));
		wr(DCFG_OFS_FMT, 8'h42);
		rdc(DCFG_OFS_FMT, 8'h41);
		wr(DCFG_OFS_PWR, 8'hE0);
		rdc(DCFG_OFS_PWR, 8'hE0);
		chk("pwr", 16'({pi, pq, prx, paux}), 16'hE);
		smp(14'h0001, 14'h0000, 1'h0);
		wr(DCFG_OFS_SPSET, 8'h20);
		chk("srst", 16'(srst), 16'h1);
		wr(DCFG_OFS_PWR, 8'hC0);
		rdc(DCFG_OFS_PWR, 8'h10);
		smp(14'h0001, 14'h0000, 1'h0);
		wr(DCFG_OFS_SPSET, 8'h00);
		chk("srst", 16'(srst), 16'h0);
		rdc(DCFG_OFS_FMT, 8'h00);
		wr(DCFG_OFS_SPSET, 8'h40);
		u_dcfg_host.lsb = 1'h1;
		rdc(DCFG_OFS_SPSET, 8'h40);
		wr(DCFG_OFS_IEN, 8'h02);
		rdc(DCFG_OFS_IEN, 8'h02);
		wr(DCFG_OFS_SPSET, 8'h80);
		u_dcfg_host.lsb = 1'h0;
		u_dcfg_host.bidir = 1'h1;
		rdc(DCFG_OFS_IEN, 8'h02);
		wr(DCFG_OFS_SPSET, 8'h00);
		u_dcfg_host.bidir = 1'h0;
		wr(DCFG_OFS_IEN, 8'hF3);
		stp(1);
		pll = 1'h1;
		stp(4);
		chk("irq", 16'(irq), 16'h1);
		pll = 1'h0;
		syn = 1'h1;
		stp(4);
		syn = 1'h0;
		rdc(DCFG_OFS_FLAG, 8'hF0);
		wr(DCFG_OFS_FLAG, 8'hFF);
		rdc(DCFG_OFS_FLAG, 8'h00);
		chk("irq", 16'(irq), 16'h0);
		stp(1);
		wp = 3'h1;
		stp(4);
		wp = 3'h2;
		stp(4);
		wp = 3'h0;
		rdc(DCFG_OFS_FLAG, 8'h03);
		wr(DCFG_OFS_IEN, 8'h00);
		chk("irq", 16'(irq), 16'h0);
		wr(DCFG_OFS_IEN, 8'h01);
		chk("irq", 16'(irq), 16'h1);
		wr(DCFG_OFS_FLAG, 8'h01);
		rdc(DCFG_OFS_FLAG, 8'h02);
		chk("irq", 16'(irq), 16'h0);
		// Clock enable low freezes the flags, so this pointer step leaves no trace.
		ce = 1'h0;
		wp = 3'h2;
		stp(4);
		wp = 3'h0;
		ce = 1'h1;
		rdc(DCFG_OFS_FLAG, 8'h02);
		rst = 1'h1;
		stp(2);
		rst = 1'h0;
		chk("pwr", 16'({pi, pq, prx, paux, irq}), 16'h2);
		rdc(DCFG_OFS_FLAG, 8'h00);
		rdc(DCFG_OFS_PWR, 8'h10);
		print_verdict();
	end
endmodule
`default_nettype wire
